// [inc/gpio_event_pkg.sv]
// package: register offsets, field positions and reset values of the gpio event port
package gpio_event_pkg;
  localparam int unsigned PIN_COUNT = 16;
  localparam int unsigned PWM_COUNT = 8;
  localparam logic [7:0] IRQ_CTRL_ADDR = 8'h06;
  localparam logic [7:0] TOP_SUMMARY_ADDR = 8'h08;
  localparam logic [7:0] TOP_ENABLE_ADDR = 8'h09;
  localparam logic [7:0] PIN_EVENT_FLAGS_ADDR = 8'h0a;
  localparam logic [7:0] PIN_EVENT_ENABLE_ADDR = 8'h0c;
  localparam logic [7:0] PWM_DONE_FLAGS_ADDR = 8'h0e;
  localparam logic [7:0] PWM_DONE_ENABLE_ADDR = 8'h0f;
  localparam logic [7:0] PIN_DIRECTION_ADDR = 8'h10;
  localparam logic [7:0] PIN_LEVEL_MONITOR_ADDR = 8'h12;
  localparam logic [7:0] PIN_OUTPUT_LEVEL_ADDR = 8'h14;
  localparam logic [7:0] PIN_FUNCTION_SELECT_ADDR = 8'h16;
  localparam int unsigned SUMMARY_GPIO_BIT = 7;
  localparam int unsigned SUMMARY_PWM_BIT = 6;
  localparam int unsigned IRQ_POL_BIT = 2;
  localparam int unsigned IRQ_TYPE_BIT = 1;
  localparam int unsigned IRQ_EN_BIT = 0;
  localparam logic [15:0] PIN_REG_RESET = 16'h0000;
  localparam logic [7:0] BYTE_REG_RESET = 8'h00;
  localparam int unsigned EDGE_PULSE_CYCLES = 1;
endpackage

// [hw/pin_sync.sv]
// two-stage synchroniser for the sixteen pad inputs
`timescale 1ns/1ps
`default_nettype none
module pin_sync (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [15:0] pin_async,
  output logic [15:0] pin_synced
);
  logic [15:0] stage_one;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      stage_one <= gpio_event_pkg::PIN_REG_RESET;
      pin_synced <= gpio_event_pkg::PIN_REG_RESET;
    end else begin
      stage_one <= pin_async;
      pin_synced <= stage_one;
    end
  end
endmodule
`default_nettype wire

// [hw/gpio_event_port.sv]
// sixteen-pin gpio port with transition flags, pwm completion flags and host interrupt
//
// Operation
// [R1] input pins set their event flag on any sampled level change
// [R2] writing one clears a pin event flag; zero leaves it
// [R3] pin flags: pins 0-7 at low byte, 8-15 at next byte
// [R4] pin enable mask gates each pin flag onto the interrupt
// [R5] pwm controller completion sets the flag bit of its index
// [R6] writing one clears a pwm completion flag; zero leaves it
// [R7] pwm enable mask gates each completion flag onto the interrupt
// [R8] host services pin flags, clears them, then clears gpio summary
// [R9] host services pwm flags, clears them, then clears pwm summary
// [R10] direction bit one makes a pin output, zero input
// [R11] pin monitor reads current pin levels and is read-only
// [R12] output level bit drives an output pin high or low
// [R13] function select one gives the pin to gpio, zero to sensor
// [R14] sixteen independent pin channels in every per-pin register
// [R15] host should set unused pins as outputs to save power
// [R16] summary bit 7 gpio, bit 6 pwm; set on events, write-one clear
// [R17] interrupt control: polarity bit 2, type bit 1, enable bit 0
// [R18] summary events are OR of enabled pin and pwm flags
`timescale 1ns/1ps
`default_nettype none
module gpio_event_port (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  output logic [7:0] reg_rdata,
  input wire logic [7:0] pwm_done,
  input wire logic [15:0] pin_in,
  output logic [15:0] pin_out,
  output logic [15:0] pin_oe,
  output logic [15:0] pin_gpio_owned,
  output logic irq_out
);
  logic [15:0] pin_level;
  logic [15:0] pin_level_prev;
  logic [15:0] pin_event_flags;
  logic [15:0] pin_event_enable;
  logic [7:0] pwm_done_flags;
  logic [7:0] pwm_done_enable;
  logic [15:0] pin_direction;
  logic [15:0] pin_output_level;
  logic [15:0] pin_function_select;
  logic [7:0] top_event_summary;
  logic [7:0] top_enable;
  logic [2:0] irq_ctrl;
  logic [15:0] pin_change;
  logic [15:0] pin_flag_clr;
  logic [7:0] pwm_flag_clr;
  logic [7:0] summary_clr;
  logic gpio_event;
  logic pwm_event;
  logic irq_request;
  logic irq_request_prev;
  logic irq_active;
  logic [7:0] next_rdata;

  function automatic logic hit(input logic [7:0] addr, input logic [7:0] target);
    hit = (addr == target);
  endfunction

  // one function covers both bytes of a sixteen-bit register
  function automatic logic [15:0] byte_write(input logic [15:0] cur, input logic [7:0] addr,
                                             input logic [7:0] base, input logic [7:0] data);
    logic [15:0] res;
    res = cur;
    if (addr == base) begin
      res[7:0] = data;
    end
    if (addr == base + 8'h01) begin
      res[15:8] = data;
    end
    byte_write = res;
  endfunction

  // ones written into a byte-split w1c register, as a sixteen-bit clear mask
  function automatic logic [15:0] byte_ones(input logic wr, input logic [7:0] addr,
                                            input logic [7:0] base, input logic [7:0] data);
    logic [15:0] res;
    res = 16'h0000;
    if (wr && addr == base) begin
      res[7:0] = data;
    end
    if (wr && addr == base + 8'h01) begin
      res[15:8] = data;
    end
    byte_ones = res;
  endfunction

  pin_sync u_pin_sync (
    .sys_clk(sys_clk),
    .rst(rst),
    .pin_async(pin_in),
    .pin_synced(pin_level)
  );

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_level_prev <= gpio_event_pkg::PIN_REG_RESET;
    end else begin
      pin_level_prev <= pin_level;
    end
  end

  // [R1] input change detect
  assign pin_change = (pin_level ^ pin_level_prev) & ~pin_direction;
  // [R2] [R3] pin flag clear mask
  assign pin_flag_clr = byte_ones(reg_wr, reg_addr, gpio_event_pkg::PIN_EVENT_FLAGS_ADDR,
                                  reg_wdata);
  // [R6] pwm flag clear mask
  assign pwm_flag_clr = (reg_wr && hit(reg_addr, gpio_event_pkg::PWM_DONE_FLAGS_ADDR)) ?
                        reg_wdata : 8'h00;
  assign summary_clr = (reg_wr && hit(reg_addr, gpio_event_pkg::TOP_SUMMARY_ADDR)) ?
                       reg_wdata : 8'h00;

  // [R1] [R2] set wins over clear
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_event_flags <= gpio_event_pkg::PIN_REG_RESET;
    end else begin
      pin_event_flags <= (pin_event_flags & ~pin_flag_clr) | pin_change;
    end
  end

  // [R5] [R6] completion flags, set wins
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pwm_done_flags <= gpio_event_pkg::BYTE_REG_RESET;
    end else begin
      pwm_done_flags <= (pwm_done_flags & ~pwm_flag_clr) | pwm_done;
    end
  end

  // [R4] [R7] [R18] enabled flags form summary events
  assign gpio_event = |(pin_event_flags & pin_event_enable);
  assign pwm_event = |(pwm_done_flags & pwm_done_enable);

  // [R16] summary bits, event held high keeps the bit set
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      top_event_summary <= gpio_event_pkg::BYTE_REG_RESET;
    end else begin
      top_event_summary <= top_event_summary & ~summary_clr;
      if (gpio_event) begin
        top_event_summary[gpio_event_pkg::SUMMARY_GPIO_BIT] <= 1'b1;
      end
      if (pwm_event) begin
        top_event_summary[gpio_event_pkg::SUMMARY_PWM_BIT] <= 1'b1;
      end
    end
  end

  // [R10] [R12] [R13] [R14] configuration registers
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_event_enable <= gpio_event_pkg::PIN_REG_RESET;
      pin_direction <= gpio_event_pkg::PIN_REG_RESET;
      pin_output_level <= gpio_event_pkg::PIN_REG_RESET;
      pin_function_select <= gpio_event_pkg::PIN_REG_RESET;
      pwm_done_enable <= gpio_event_pkg::BYTE_REG_RESET;
      top_enable <= gpio_event_pkg::BYTE_REG_RESET;
      irq_ctrl <= 3'h0;
    end else if (reg_wr) begin
      pin_event_enable <= byte_write(pin_event_enable, reg_addr,
                                     gpio_event_pkg::PIN_EVENT_ENABLE_ADDR, reg_wdata);
      pin_direction <= byte_write(pin_direction, reg_addr,
                                  gpio_event_pkg::PIN_DIRECTION_ADDR, reg_wdata);
      pin_output_level <= byte_write(pin_output_level, reg_addr,
                                     gpio_event_pkg::PIN_OUTPUT_LEVEL_ADDR, reg_wdata);
      pin_function_select <= byte_write(pin_function_select, reg_addr,
                                        gpio_event_pkg::PIN_FUNCTION_SELECT_ADDR, reg_wdata);
      if (hit(reg_addr, gpio_event_pkg::PWM_DONE_ENABLE_ADDR)) begin
        pwm_done_enable <= reg_wdata;
      end
      if (hit(reg_addr, gpio_event_pkg::TOP_ENABLE_ADDR)) begin
        top_enable <= reg_wdata;
      end
      if (hit(reg_addr, gpio_event_pkg::IRQ_CTRL_ADDR)) begin
        irq_ctrl <= reg_wdata[2:0];
      end
    end
  end

  // [R10] [R12] [R13] pad drive, registered
  always_ff @(posedge sys_clk) begin
    if (rst) begin
      pin_out <= gpio_event_pkg::PIN_REG_RESET;
      pin_oe <= gpio_event_pkg::PIN_REG_RESET;
      pin_gpio_owned <= gpio_event_pkg::PIN_REG_RESET;
    end else begin
      pin_out <= pin_output_level;
      pin_oe <= pin_direction & pin_function_select;
      pin_gpio_owned <= pin_function_select;
    end
  end

  // [R17] interrupt generation; edge mode gives a one-cycle pulse on a new request
  assign irq_request = |(top_event_summary & top_enable) & irq_ctrl[gpio_event_pkg::IRQ_EN_BIT];
  assign irq_active = irq_ctrl[gpio_event_pkg::IRQ_TYPE_BIT] ?
                      (irq_request & ~irq_request_prev) : irq_request;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      irq_request_prev <= 1'b0;
      irq_out <= 1'b1;
    end else begin
      irq_request_prev <= irq_request;
      irq_out <= irq_ctrl[gpio_event_pkg::IRQ_POL_BIT] ? irq_active : ~irq_active;
    end
  end

  // [R11] read mux; monitor is read-only, unmapped reads zero
  always_comb begin
    next_rdata = 8'h00;
    case (reg_addr)
      gpio_event_pkg::IRQ_CTRL_ADDR: next_rdata = {5'h00, irq_ctrl};
      gpio_event_pkg::TOP_SUMMARY_ADDR: next_rdata = top_event_summary;
      gpio_event_pkg::TOP_ENABLE_ADDR: next_rdata = top_enable;
      8'h0a: next_rdata = pin_event_flags[7:0];
      8'h0b: next_rdata = pin_event_flags[15:8];
      8'h0c: next_rdata = pin_event_enable[7:0];
      8'h0d: next_rdata = pin_event_enable[15:8];
      gpio_event_pkg::PWM_DONE_FLAGS_ADDR: next_rdata = pwm_done_flags;
      gpio_event_pkg::PWM_DONE_ENABLE_ADDR: next_rdata = pwm_done_enable;
      8'h10: next_rdata = pin_direction[7:0];
      8'h11: next_rdata = pin_direction[15:8];
      8'h12: next_rdata = pin_level[7:0];
      8'h13: next_rdata = pin_level[15:8];
      8'h14: next_rdata = pin_output_level[7:0];
      8'h15: next_rdata = pin_output_level[15:8];
      8'h16: next_rdata = pin_function_select[7:0];
      8'h17: next_rdata = pin_function_select[15:8];
      default: next_rdata = 8'h00;
    endcase
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      reg_rdata <= 8'h00;
    end else if (reg_rd) begin
      reg_rdata <= next_rdata;
    end
  end

  // pin flag set by an input change one cycle later
  pin_flag_set_a: assert property (@(posedge sys_clk) disable iff (rst) // [R1]
    (|pin_change) |=> ((pin_event_flags & $past(pin_change)) == $past(pin_change)))
    else $error("pin change did not set its flag");

  pin_flag_clr_a: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
    (pin_flag_clr[0] && !pin_change[0]) |=> !pin_event_flags[0])
    else $error("pin flag not cleared by write of one");

  pin_flag_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [R2]
    (pin_event_flags[3] && !pin_flag_clr[3]) |=> pin_event_flags[3])
    else $error("pin flag lost without a clear");

  upper_byte_clr_a: assert property (@(posedge sys_clk) disable iff (rst) // [R3]
    (reg_wr && reg_addr == 8'h0b && reg_wdata[0] && !pin_change[8]) |=> !pin_event_flags[8])
    else $error("upper byte write did not clear pin 8");

  pwm_flag_set_a: assert property (@(posedge sys_clk) disable iff (rst) // [R5]
    pwm_done[5] |=> pwm_done_flags[5])
    else $error("pwm completion flag not set");

  pwm_flag_clr_a: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
    (pwm_flag_clr[2] && !pwm_done[2]) |=> !pwm_done_flags[2])
    else $error("pwm flag not cleared by write of one");

  gpio_summary_a: assert property (@(posedge sys_clk) disable iff (rst) // [R4]
    gpio_event |=> top_event_summary[7])
    else $error("enabled pin flag did not set summary");

  pwm_summary_a: assert property (@(posedge sys_clk) disable iff (rst) // [R7]
    (!pwm_event && !gpio_event && top_event_summary == 8'h00) |=> !top_event_summary[6])
    else $error("pwm summary set without enabled flag");

  output_drive_a: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    ##1 (pin_oe == $past(pin_direction & pin_function_select)))
    else $error("pad enable does not follow direction");

  level_irq_a: assert property (@(posedge sys_clk) disable iff (rst) // [R17]
    (irq_request && !irq_ctrl[1] && irq_ctrl[2] && $stable(irq_ctrl)) |=> irq_out)
    else $error("active-high level interrupt not asserted");

  // further checks on the monitor read, summary bits, interrupt pin, pad copies and flags
  monitor_read_a: assert property (@(posedge sys_clk) disable iff (rst) // [R11]
    (reg_rd && reg_addr == 8'h12) |=> (reg_rdata == $past(pin_level[7:0])))
    else $error("monitor read does not show pin levels");

  summary_clr_a: assert property (@(posedge sys_clk) disable iff (rst) // [R16]
    (summary_clr[7] && !gpio_event) |=> !top_event_summary[7])
    else $error("gpio summary not cleared by write of one");

  summary_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [R16]
    (top_event_summary[6] && !summary_clr[6]) |=> top_event_summary[6])
    else $error("pwm summary lost without a clear");

  irq_disable_a: assert property (@(posedge sys_clk) disable iff (rst) // [R17]
    !irq_ctrl[0] |=> (irq_out == !$past(irq_ctrl[2])))
    else $error("disabled interrupt pin not at inactive level");

  edge_irq_a: assert property (@(posedge sys_clk) disable iff (rst) // [R17]
    (irq_ctrl == 3'h7 && irq_request_prev) |=> !irq_out)
    else $error("edge interrupt longer than one cycle");

  owned_copy_a: assert property (@(posedge sys_clk) disable iff (rst) // [R13]
    ##1 (pin_gpio_owned == $past(pin_function_select)))
    else $error("pin ownership does not follow function select");

  pin_level_out_a: assert property (@(posedge sys_clk) disable iff (rst) // [R12]
    ##1 (pin_out == $past(pin_output_level)))
    else $error("pad level does not follow output register");

  pwm_flag_hold_a: assert property (@(posedge sys_clk) disable iff (rst) // [R6]
    (pwm_done_flags[1] && !pwm_flag_clr[1]) |=> pwm_done_flags[1])
    else $error("pwm flag lost without a clear");

  upper_pin_set_a: assert property (@(posedge sys_clk) disable iff (rst) // [R14]
    pin_change[15] |=> pin_event_flags[15])
    else $error("pin 15 change did not set its flag");

  output_no_flag_a: assert property (@(posedge sys_clk) disable iff (rst) // [R10]
    (pin_direction[0] && !pin_event_flags[0]) |=> !pin_event_flags[0])
    else $error("output pin raised an event flag");

  pin_event_c: cover property (@(posedge sys_clk) disable iff (rst) |pin_change ##1 gpio_event);
  pwm_event_c: cover property (@(posedge sys_clk) disable iff (rst) |pwm_done ##1 pwm_event);
  edge_irq_c: cover property (@(posedge sys_clk) disable iff (rst) irq_ctrl[1] && irq_active);
  monitor_read_c: cover property (@(posedge sys_clk) disable iff (rst) reg_rd && reg_addr == 8'h13);
  summary_clear_c: cover property (@(posedge sys_clk) disable iff (rst) |summary_clr);
endmodule
`default_nettype wire

// [verification/pin_far_side.sv]
// far-side model: pads joined to the port and to outside circuitry
`timescale 1ns/1ps
`default_nettype none
module pin_far_side (
  input wire logic [15:0] pin_out,
  input wire logic [15:0] pin_oe,
  input wire logic [15:0] ext_level,
  output logic [15:0] pin_in
);
  // driven pads show the port level
  // outside drivers win only where the port lets go, so no pad floats
  assign pin_in = (pin_out & pin_oe) | (ext_level & ~pin_oe);
endmodule
`default_nettype wire

// [verification/testbench.sv]
// self-checking bench for the gpio event port
`timescale 1ns/1ps
`default_nettype none
`define chk(n, e, g) begin compares++; if ((g) !== (e)) begin num_errors++; \
  $display("wrong value %s exp %h got %h", n, e, g); end end
module testbench;
  localparam logic [15:0] DIR = 16'h00ff;
  localparam logic [15:0] FS = 16'h0f0f;
  localparam logic [15:0] OUTL = 16'h00a5;
  localparam logic [15:0] EXT = 16'h3c00;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic [7:0] reg_addr = 8'h00;
  logic [7:0] reg_wdata = 8'h00;
  logic [7:0] pwm_done = 8'h00;
  logic [15:0] ext_level = 16'h0000;
  logic [7:0] rw_addr [9] = '{8'h0c, 8'h0d, 8'h0f, 8'h10, 8'h11, 8'h14, 8'h15, 8'h16, 8'h17};
  wire [7:0] reg_rdata;
  wire [15:0] pin_in;
  wire [15:0] pin_out;
  wire [15:0] pin_oe;
  wire [15:0] pin_gpio_owned;
  wire irq_out;
  int num_errors = 0;
  int compares = 0;
  int n;
  gpio_event_port gpio_event_port_inst (.sys_clk(sys_clk), .rst(rst), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_rdata(reg_rdata),
    .pwm_done(pwm_done), .pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe),
    .pin_gpio_owned(pin_gpio_owned), .irq_out(irq_out));
  pin_far_side pin_far_side_inst (.pin_out(pin_out), .pin_oe(pin_oe),
    .ext_level(ext_level), .pin_in(pin_in));
  initial begin
    forever #4 sys_clk = ~sys_clk;
  end
  task automatic close_out();
    if (num_errors == 0 && compares > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask
  task automatic tick(input int c);
    repeat (c) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
  endtask
  // reply lands on the same edge that takes the strobe
  task automatic rd(input logic [7:0] a, input logic [7:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1;
    `chk($sformatf("reg_%h", a), e, reg_rdata)
  endtask
  task automatic wait_irq(input logic lvl);
    n = 0;
    while (irq_out !== lvl && n < 20) begin
      tick(1);
      n++;
    end
    if (n == 20) begin
      num_errors++;
      close_out();
    end
  endtask
  task automatic pwm_pulse(input logic [7:0] p);
    @(posedge sys_clk);
    pwm_done <= p;
    @(posedge sys_clk);
    pwm_done <= 8'h00;
  endtask
  initial begin
    repeat (10) @(posedge sys_clk);
    rst <= 1'b0;
    tick(1);
    `chk("irq_out", 1'b1, irq_out)
    for (int a = 6; a <= 8'h17; a++) rd(8'(a), 8'h00);
    rd(8'h20, 8'h00);
    foreach (rw_addr[i]) wr(rw_addr[i], rw_addr[i] ^ 8'ha5);
    foreach (rw_addr[i]) rd(rw_addr[i], rw_addr[i] ^ 8'ha5);
    // unused upper pins stay inputs here only to watch their edges
    wr(8'h10, DIR[7:0]);
    wr(8'h11, DIR[15:8]);
    wr(8'h16, FS[7:0]);
    wr(8'h17, FS[15:8]);
    wr(8'h14, OUTL[7:0]);
    wr(8'h15, OUTL[15:8]);
    wr(8'h0c, 8'h00);
    wr(8'h0d, 8'h00);
    wr(8'h0f, 8'h20);
    @(posedge sys_clk);
    ext_level <= EXT;
    tick(6);
    `chk("pin_oe", DIR & FS, pin_oe)
    `chk("pin_out", OUTL, pin_out)
    `chk("pin_gpio_owned", FS, pin_gpio_owned)
    rd(8'h12, 8'h05);
    rd(8'h13, 8'h3c);
    wr(8'h12, 8'hff);
    rd(8'h12, 8'h05);
    wr(8'h0a, 8'hff);
    wr(8'h0b, 8'hff);
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h00);
    // output pins and a driven-direction pin must not flag
    wr(8'h14, OUTL[7:0] | 8'h08);
    @(posedge sys_clk);
    ext_level <= EXT ^ 16'h1280;
    tick(6);
    `chk("pin_out", OUTL | 16'h0008, pin_out)
    rd(8'h0a, 8'h00);
    rd(8'h0b, 8'h12);
    wr(8'h0b, 8'h10);
    rd(8'h0b, 8'h02);
    wr(8'h0b, 8'h00);
    rd(8'h0b, 8'h02);
    wr(8'h0d, 8'h02);
    wr(8'h09, 8'hc0);
    wr(8'h06, 8'h01);
    wait_irq(1'b0);
    rd(8'h08, 8'h80);
    rd(8'h0b, 8'h02);
    wr(8'h0b, 8'h02);
    wr(8'h08, 8'h80);
    wait_irq(1'b1);
    rd(8'h08, 8'h00);
    @(posedge sys_clk);
    ext_level <= EXT ^ 16'h0280;
    tick(6);
    rd(8'h0b, 8'h10);
    rd(8'h08, 8'h00);
    `chk("irq_out", 1'b1, irq_out)
    pwm_pulse(8'h24);
    tick(4);
    `chk("irq_out", 1'b0, irq_out)
    rd(8'h0e, 8'h24);
    rd(8'h08, 8'h40);
    rd(8'h0e, 8'h24);
    wr(8'h0e, 8'h20);
    rd(8'h0e, 8'h04);
    wr(8'h08, 8'h40);
    wait_irq(1'b1);
    rd(8'h08, 8'h00);
    wr(8'h06, 8'h05);
    tick(3);
    `chk("irq_out", 1'b0, irq_out)
    wr(8'h06, 8'h07);
    pwm_pulse(8'h20);
    n = 0;
    repeat (10) begin
      tick(1);
      if (irq_out === 1'b1) n++;
    end
    `chk("irq pulses", gpio_event_pkg::EDGE_PULSE_CYCLES, n)
    close_out();
  end
  initial begin
    repeat (20000) @(posedge sys_clk);
    num_errors++;
    close_out();
  end
endmodule
`default_nettype wire
